// File: bench/sfb_core_tb.sv
// self-checking bench for the serial port fault, single-wire and low-power core
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module sfb_core_tb;
   import sfb_pkg::*;
   logic       mclk, nrst, clkEn, linkEnable, selectOutputEnable, faultDetectEnable;
   logic       singleWireSelect, stopInWait, waitMode, cr1Write, masterIn, cr2Write;
   logic       wireOeIn, statusRead, dataRead, dataWrite, selLow, slaveOn;
   logic [7:0] txData, rxData, pTx, pRx;
   logic       masterSelect, singleWireOutputEnable, modeFaultFlag, transferDoneFlag;
   logic       txEmptyFlag, irq, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, ssOut, select_output_enable;
   logic       pSck, pSs, pMosi, pMosiOe, pMiso, pMisoOe, s;
   wire        sckPin, mosiPin, misoPin, ssPin;
   int         miscompares, num_checks;
   // data lines idle high through pull-ups when nobody drives them
   assign sckPin  = sckOe ? sckOut : pSck;
   assign mosiPin = mosiOe ? mosiOut : (pMosiOe ? pMosi : 1'b1);
   assign misoPin = misoOe ? misoOut : (pMisoOe ? pMiso : 1'b1);
   assign ssPin   = select_output_enable ? ssOut : pSs;
   sfb_core #(.HALF(4)) dut (.mclk(mclk), .nrst(nrst), .clkEn(clkEn), .linkEnable(linkEnable),
      .selectOutputEnable(selectOutputEnable), .faultDetectEnable(faultDetectEnable),
      .singleWireSelect(singleWireSelect), .stopInWait(stopInWait), .waitMode(waitMode),
      .cr1Write(cr1Write), .masterIn(masterIn), .cr2Write(cr2Write), .wireOeIn(wireOeIn),
      .statusRead(statusRead), .dataRead(dataRead), .dataWrite(dataWrite), .txData(txData),
      .rxData(rxData), .masterSelect(masterSelect),
      .singleWireOutputEnable(singleWireOutputEnable),
      .modeFaultFlag(modeFaultFlag), .transferDoneFlag(transferDoneFlag),
      .txEmptyFlag(txEmptyFlag), .irq(irq), .sckIn(sckPin), .sckOut(sckOut), .sckOe(sckOe),
      .mosiIn(mosiPin), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoPin),
      .misoOut(misoOut), .misoOe(misoOe), .ssIn(ssPin), .ssOut(ssOut), .select_output_enable(select_output_enable));
   sfb_partner u_part (.sckPin(sckPin), .mosiPin(mosiPin), .misoPin(misoPin), .ssPin(ssPin),
      .selLow(selLow), .slaveOn(slaveOn), .txByte(pTx), .pSck(pSck), .pSs(pSs), .pMosi(pMosi),
      .pMosiOe(pMosiOe), .pMiso(pMiso), .pMisoOe(pMisoOe), .rxByte(pRx));
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // =======================================================
   // access tasks
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // k: 0 control 1, 1 control 2, 2 status read, 3 data read, else data write
   task automatic strobe(input int k, input logic [7:0] d);
      @(negedge mclk);
      txData = d;
      masterIn = d[0];
      wireOeIn = d[0];
      case (k)
         0: cr1Write = 1'b1;
         1: cr2Write = 1'b1;
         2: statusRead = 1'b1;
         3: dataRead = 1'b1;
         default: dataWrite = 1'b1;
      endcase
      @(negedge mclk);
      {cr1Write, cr2Write, statusRead, dataRead, dataWrite} = 5'h00;
   endtask
   task automatic clear_done();
      strobe(2, 8'h00);
      strobe(3, 8'h00);
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (transferDoneFlag !== 1'b1 && n < 3000)
      begin
         @(negedge mclk);
         n++;
      end
      if (n >= 3000)
      begin
         miscompares++;
         $display("[ERR] %0t done flag never rose", $time);
         print_verdict();
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // =======================================================
   // main sequence
   initial
   begin
      miscompares = 0;
      num_checks = 0;
      {nrst, linkEnable, selectOutputEnable, faultDetectEnable, singleWireSelect} = 5'h00;
      {stopInWait, waitMode, cr1Write, masterIn, cr2Write, wireOeIn} = 6'h00;
      {statusRead, dataRead, dataWrite, selLow} = 4'h0;
      clkEn = 1'b1;
      slaveOn = 1'b1;
      txData = 8'h00;
      pTx = 8'h3C;
      idle(6);
      nrst = 1'b1;
      `CHK({rxData, transferDoneFlag, modeFaultFlag, irq}, 11'h000)
      // master with select output: frame, pause in wait, freeze in stop
      {linkEnable, faultDetectEnable, selectOutputEnable} = 3'h7;
      strobe(0, 8'h01);
      strobe(4, 8'hA5);
      idle(10);
      `CHK({select_output_enable, ssOut, sckOe, misoOe}, 4'hA)
      `CHK(txEmptyFlag, 1'b1)
      stopInWait = 1'b1;
      waitMode = 1'b1;
      idle(2);
      s = sckOut;
      idle(30);
      `CHK({sckOut, ssOut, transferDoneFlag}, {s, 2'h0})
      waitMode = 1'b0;
      idle(9);
      clkEn = 1'b0;
      s = sckOut;
      idle(30);
      `CHK({sckOut, ssOut}, {s, 1'b0})
      clkEn = 1'b1;
      wait_done();
      `CHK({rxData, pRx, ssOut, irq}, {8'h3C, 8'hA5, 2'h3})
      linkEnable = 1'b0;
      idle(1);
      `CHK(irq, 1'b0)
      clear_done();
      `CHK({transferDoneFlag, sckOe, select_output_enable}, 3'h0)
      linkEnable = 1'b1;
      // select low ignored without fault detection
      faultDetectEnable = 1'b0;
      idle(1);
      `CHK(select_output_enable, 1'b0)
      selectOutputEnable = 1'b0;
      selLow = 1'b1;
      idle(10);
      `CHK({modeFaultFlag, masterSelect}, 2'h1)
      selLow = 1'b0;
      // single-wire master: data out and back in on the master-out pin
      {faultDetectEnable, selectOutputEnable, singleWireSelect} = 3'h7;
      strobe(1, 8'h01);
      strobe(4, 8'h81);
      idle(10);
      `CHK({mosiOe, misoOe}, 2'h2)
      wait_done();
      `CHK({rxData, pRx}, 16'h8181)
      clear_done();
      // fault while single-wire master, then clear sequence
      selectOutputEnable = 1'b0;
      selLow = 1'b1;
      idle(8);
      `CHK({modeFaultFlag, masterSelect, singleWireOutputEnable, irq}, 4'h9)
      `CHK({sckOe, mosiOe, misoOe}, 3'h0)
      selLow = 1'b0;
      idle(4);
      strobe(2, 8'h00);
      strobe(0, 8'h00);
      idle(1);
      `CHK(modeFaultFlag, 1'b0)
      // slave frames from the model master
      singleWireSelect = 1'b0;
      slaveOn = 1'b0;
      strobe(4, 8'h96);
      u_part.master_xfer(8'h5A);
      wait_done();
      `CHK({rxData, pRx, sckOe, select_output_enable, modeFaultFlag}, {16'h5A96, 3'h0})
      clear_done();
      // wait entered and left while idle gives no completion
      waitMode = 1'b1;
      u_part.master_xfer(8'h11);
      waitMode = 1'b0;
      idle(10);
      `CHK(transferDoneFlag, 1'b0)
      // wait entered mid-frame: completion held until exit
      fork
         u_part.master_xfer(8'h22);
         begin
            idle(30);
            waitMode = 1'b1;
         end
      join
      idle(10);
      `CHK(transferDoneFlag, 1'b0)
      waitMode = 1'b0;
      idle(10);
      `CHK({transferDoneFlag, rxData}, 9'h122)
      // wait with the stop option clear keeps the slave running
      stopInWait = 1'b0;
      waitMode = 1'b1;
      clear_done();
      u_part.master_xfer(8'h33);
      wait_done();
      `CHK({transferDoneFlag, rxData}, 9'h133)
      waitMode = 1'b0;
      print_verdict();
   end
endmodule
`default_nettype wire

// File: bench/sfb_partner.sv
// far-side serial device model: slave for a master port, master for a slave port
`timescale 1ns/100ps
`default_nettype none
module sfb_partner
(
   input  wire logic       sckPin,   // resolved clock line
   input  wire logic       mosiPin,  // resolved master-out line
   input  wire logic       misoPin,  // resolved master-in line
   input  wire logic       ssPin,    // resolved select line
   input  wire logic       selLow,   // bench pulls select low
   input  wire logic       slaveOn,  // act as slave on select
   input  wire logic [7:0] txByte,   // byte the model sends
   output logic            pSck,     // clock drive as master
   output logic            pSs,      // select drive
   output logic            pMosi,    // master-out drive
   output logic            pMosiOe,  // master-out enable
   output logic            pMiso,    // master-in drive
   output logic            pMisoOe,  // master-in enable
   output logic      [7:0] rxByte    // byte the model received
);
   logic       mAct;
   logic       ssDrv;
   logic [7:0] sh;
   initial
   begin
      mAct = 1'b0;
      ssDrv = 1'b1;
      pSck = 1'b0;
      pMosi = 1'b0;
      pMosiOe = 1'b0;
      sh = 8'h00;
      rxByte = 8'h00;
   end
   assign pSs = ssDrv & ~selLow;
   assign pMiso = sh[7];
   assign pMisoOe = slaveOn & ~ssPin & ~mAct;
   // =======================================================
   // slave role: load on select, sample on rise, shift on fall
   always @(negedge ssPin)
      if (slaveOn)
         sh = txByte;
   always @(posedge sckPin)
      rxByte = {rxByte[6:0], (mAct ? misoPin : mosiPin)};
   // shifted-in fill is inverted so a stale bit never looks valid
   always @(negedge sckPin)
      if (!mAct)
         sh = {sh[6:0], ~sh[0]};
   // =======================================================
   // master role: mode 0, msb first, clock idle low between frames
   task automatic master_xfer(input logic [7:0] b);
      logic [7:0] s;
      s = b;
      #7;
      mAct = 1'b1;
      pMosiOe = 1'b1;
      pMosi = s[7];
      ssDrv = 1'b0;
      #80;
      for (int i = 0; i < 8; i++)
      begin
         pSck = 1'b1;
         #80;
         pSck = 1'b0;
         s = {s[6:0], ~s[0]};
         pMosi = s[7];
         #80;
      end
      ssDrv = 1'b1;
      pMosiOe = 1'b0;
      mAct = 1'b0;
      #80;
   endtask
endmodule
`default_nettype wire

// File: rtl/sfb_core.sv
// serial port core: select output, single-wire data, mode fault, low power
`timescale 1ns/100ps
`default_nettype none
module sfb_core
   import sfb_pkg::*;
#(
   parameter int unsigned HALF = HALF_CYC
)
(
   input  wire logic        mclk,             // module clock
   input  wire logic        nrst,             // sync reset, active low
   input  wire logic        clkEn,            // low = module clock stopped
   input  wire logic        linkEnable,       // port enable level
   input  wire logic        selectOutputEnable, // select output option
   input  wire logic        faultDetectEnable,  // mode fault detection option
   input  wire logic        singleWireSelect, // one data pin mode
   input  wire logic        stopInWait,       // halt in cpu wait
   input  wire logic        waitMode,         // cpu in wait
   input  wire logic        cr1Write,         // control register 1 write strobe
   input  wire logic        masterIn,         // master select value written
   input  wire logic        cr2Write,         // control register 2 write strobe
   input  wire logic        wireOeIn,         // single-wire drive value written
   input  wire logic        statusRead,       // status register read strobe
   input  wire logic        dataRead,         // data register read strobe
   input  wire logic        dataWrite,        // data register write strobe
   input  wire logic [7:0]  txData,           // data written
   output logic      [7:0]  rxData,           // data register read value
   output logic             masterSelect,     // current master select
   output logic             singleWireOutputEnable, // current drive enable
   output logic             modeFaultFlag,    // mode fault flag
   output logic             transferDoneFlag, // transfer done flag
   output logic             txEmptyFlag,      // transmit empty flag
   output logic             irq,              // interrupt request
   input  wire logic        sckIn,            // clock pin input
   output logic             sckOut,           // clock pin output
   output logic             sckOe,            // clock pin enable
   input  wire logic        mosiIn,           // master-out pin input
   output logic             mosiOut,          // master-out pin output
   output logic             mosiOe,           // master-out pin enable
   input  wire logic        misoIn,           // master-in pin input
   output logic             misoOut,          // master-in pin output
   output logic             misoOe,           // master-in pin enable
   input  wire logic        ssIn,             // select pin input, low active
   output logic             ssOut,            // select pin output
   output logic             select_output_enable              // select pin enable
);
   typedef struct packed
   {
      logic             master;
      logic             wireOe;
      logic             modeFault;
      logic             modeFaultArm;
      logic             done;
      logic             doneArm;
      logic             txEmpty;
      logic             txArm;
      logic             txFull;
      logic [7:0]       txBuf;
      logic [7:0]       rxData;
      logic [7:0]       shreg;
      logic             rxBit;
      logic [CNT_W-1:0] cnt;
      logic [DIV_W-1:0] div;
      logic             sckLevel;
      logic             busy;
      logic             sckPrev;
      logic             ssPrev;
      logic             holdPrev;
      logic             entryBusy;
      logic             pend;
      logic [7:0]       pendData;
      logic             waitUseData;
   } sfb_core_t;

   sfb_core_t   st;
   sfb_core_t   next_st;
   logic [3:0]  syn;
   logic        ssS;
   logic        sckS;
   logic        rxPin;
   logic        ssoActive;
   logic        faultArmed;
   logic        masterHold;
   logic        slaveHold;
   logic        rise;
   logic        fall;
   logic        ssFall;
   logic        mid;
   logic [7:0]  newByte;

   // =======================================================
   // pin synchronisers
   sfb_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync
   (
      .mclk  (mclk),
      .nrst  (nrst),
      .clkEn (clkEn),
      .din   ({ssIn, sckIn, mosiIn, misoIn}),
      .dout  (syn)
   );

   assign ssS  = syn[SY_SS];
   assign sckS = syn[SY_SCK];
   assign rxPin = st.master ? (singleWireSelect ? syn[SY_MOSI] : syn[SY_MISO])
                            : (singleWireSelect ? syn[SY_MISO] : syn[SY_MOSI]);

   // =======================================================
   // mode decode
   assign ssoActive  = st.master && selectOutputEnable && faultDetectEnable;
   assign faultArmed = st.master && faultDetectEnable && !ssoActive && linkEnable;
   assign masterHold = st.master && stopInWait && waitMode;
   assign slaveHold  = !st.master && stopInWait && waitMode;
   assign ssFall     = !ssS && st.ssPrev;
   assign mid        = st.busy || (st.cnt != CNT_ZERO);
   assign newByte    = {st.shreg[6:0], st.rxBit};
   assign rise       = st.master ? (st.busy && !masterHold && st.div == DIV_W'(HALF - 1)
                                    && !st.sckLevel)
                                 : (sckS && !st.sckPrev && !ssS);
   assign fall       = st.master ? (st.busy && !masterHold && st.div == DIV_W'(HALF - 1)
                                    && st.sckLevel)
                                 : (!sckS && st.sckPrev && !ssS);

   // =======================================================
   // next state
   always_comb
   begin
      next_st = st;
      if (clkEn)
      begin
         next_st.sckPrev  = sckS;
         next_st.ssPrev   = ssS;
         next_st.holdPrev = slaveHold;
         // software side, live even with the link disabled
         if (cr1Write)
         begin
            next_st.master = masterIn;
         end
         if (cr2Write)
         begin
            next_st.wireOe = wireOeIn;
         end
         if (statusRead)
         begin
            next_st.modeFaultArm = st.modeFault;
            next_st.doneArm = st.done;
            next_st.txArm   = st.txEmpty;
         end
         if (cr1Write && st.modeFaultArm)
         begin
            next_st.modeFault    = 1'b0;
            next_st.modeFaultArm = 1'b0;
         end
         if (dataRead && st.doneArm)
         begin
            next_st.done    = 1'b0;
            next_st.doneArm = 1'b0;
         end
         if (dataWrite)
         begin
            next_st.txBuf  = txData;
            next_st.txFull = 1'b1;
            if (st.txArm)
            begin
               next_st.txEmpty = 1'b0;
               next_st.txArm   = 1'b0;
            end
         end
         // core logic
         if (!linkEnable)
         begin
            next_st.busy     = 1'b0;
            next_st.cnt      = CNT_ZERO;
            next_st.sckLevel = 1'b0;
            next_st.div      = '0;
         end
         else
         begin
            // master start
            if (st.master && !st.busy && st.txFull && !masterHold && !dataWrite)
            begin
               next_st.busy     = 1'b1;
               next_st.shreg    = st.txBuf;
               next_st.txFull   = 1'b0;
               next_st.txEmpty  = 1'b1;
               next_st.cnt      = CNT_ZERO;
               next_st.div      = '0;
               next_st.sckLevel = 1'b0;
            end
            else if (st.master && st.busy && !masterHold)
            begin
               next_st.div = st.div + 1'b1;
               if (st.div == DIV_W'(HALF - 1))
               begin
                  next_st.div      = '0;
                  next_st.sckLevel = !st.sckLevel;
               end
            end
            // slave frame start picks what to send
            if (!st.master && ssFall)
            begin
               next_st.cnt = CNT_ZERO;
               if (slaveHold ? st.waitUseData : st.txFull)
               begin
                  next_st.shreg = st.txBuf;
                  if (!slaveHold)
                  begin
                     next_st.txFull  = dataWrite;
                     next_st.txEmpty = 1'b1;
                  end
               end
            end
            if (!st.master && ssS)
            begin
               next_st.cnt = CNT_ZERO;  // frame ended early
            end
            if (rise)
            begin
               next_st.rxBit = rxPin;
            end
            if (fall)
            begin
               next_st.shreg = newByte;
               next_st.cnt   = st.cnt + 1'b1;
               if (st.cnt == CNT_LAST)
               begin
                  next_st.cnt  = CNT_ZERO;
                  next_st.busy = 1'b0;
                  if (slaveHold)
                  begin
                     next_st.pend     = 1'b1;
                     next_st.pendData = newByte;
                  end
                  else
                  begin
                     next_st.rxData = newByte;
                     next_st.done   = 1'b1;
                  end
               end
            end
         end
         // wait entry and exit for the slave
         if (slaveHold && !st.holdPrev)
         begin
            next_st.pend        = 1'b0;
            next_st.entryBusy   = mid;
            next_st.waitUseData = st.txFull;
         end
         if (!slaveHold && st.holdPrev)
         begin
            next_st.pend = 1'b0;
            if (st.pend && (st.entryBusy || mid))
            begin
               next_st.rxData = st.pendData;
               next_st.done   = 1'b1;
            end
         end
         // mode fault last, so a new fault beats a clear
         if (faultArmed && !ssS)
         begin
            next_st.modeFault    = 1'b1;
            next_st.modeFaultArm = 1'b0;
            next_st.master   = 1'b0;
            next_st.busy     = 1'b0;
            next_st.cnt      = CNT_ZERO;
            next_st.div      = '0;
            next_st.sckLevel = 1'b0;
            if (singleWireSelect)
            begin
               next_st.wireOe = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         st          <= '0;
         st.rxData   <= DATA_RST;
         st.ssPrev   <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // =======================================================
   // pins and status
   // fault keeps every output released until software clears it
   assign sckOut  = st.sckLevel;
   assign sckOe   = st.master && linkEnable && !st.modeFault;
   assign ssOut   = !st.busy;
   assign select_output_enable    = ssoActive && linkEnable && !st.modeFault;
   assign mosiOut = st.shreg[7];
   assign misoOut = st.shreg[7];
   assign mosiOe  = st.master && linkEnable && !st.modeFault
                    && (!singleWireSelect || st.wireOe);
   assign misoOe  = !st.master && linkEnable && !st.modeFault
                    && (singleWireSelect ? st.wireOe : !ssS);

   assign rxData                 = st.rxData;
   assign masterSelect           = st.master;
   assign singleWireOutputEnable = st.wireOe;
   assign modeFaultFlag          = st.modeFault;
   assign transferDoneFlag       = st.done;
   assign txEmptyFlag            = st.txEmpty;
   assign irq = linkEnable && (st.modeFault || st.done || st.txEmpty);

   // =======================================================
   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   sso_drive_a: assert property (select_output_enable && st.cnt != CNT_ZERO |-> !ssOut)
      else $error("select output not low during transfer");
   sso_avail_a: assert property (select_output_enable |-> st.master && faultDetectEnable
                                 && selectOutputEnable)
      else $error("select output enabled outside master option");
   fault_set_a: assert property (clkEn && faultArmed && !ssS |=> st.modeFault && !st.master
                                 && !st.busy)
      else $error("mode fault not taken");
   fault_cause_a: assert property ($rose(st.modeFault) |-> $past(st.master && faultDetectEnable
                                   && !ssoActive))
      else $error("mode fault without master and detect enable");
   fault_pins_a: assert property (st.modeFault |-> !sckOe && !mosiOe && !misoOe)
      else $error("pins driven during mode fault");
   wire_clear_a: assert property (clkEn && faultArmed && !ssS && singleWireSelect
                                  |=> !st.wireOe)
      else $error("single-wire drive kept after fault");
   slave_sck_a: assert property (!st.master |-> !sckOe)
      else $error("slave drives clock");
   single_pin_a: assert property (singleWireSelect && st.master |-> !misoOe)
      else $error("unused pin driven in single-wire");
   master_pause_a: assert property (clkEn && masterHold && st.busy && linkEnable
                                    && !(faultArmed && !ssS)
                                    |=> $stable(st.cnt) && $stable(st.sckLevel))
      else $error("master moved during wait");
   slave_defer_a: assert property (clkEn && slaveHold && st.holdPrev |=> !$rose(st.done))
      else $error("done flag set during slave wait");
   irq_gate_a: assert property (!linkEnable |-> !irq)
      else $error("interrupt while disabled");
endmodule
`default_nettype wire

// File: rtl/sfb_pkg.sv
// shared constants for the serial port fault, single-wire and low-power logic
package sfb_pkg;
   // =======================================================
   // transfer shape
   localparam int unsigned WORD_BITS = 8;
   localparam int unsigned CNT_W     = 4;
   localparam logic [CNT_W-1:0] CNT_LAST = 4'h7;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   // =======================================================
   // master serial clock timing
   localparam int unsigned MCLK_HZ  = 50_000_000;
   localparam int unsigned SCK_HZ   = 6_250_000;
   localparam int unsigned HALF_CYC = MCLK_HZ / (2 * SCK_HZ);
   localparam int unsigned DIV_W    = 8;
   // =======================================================
   // synchroniser lanes: {select, clock, master-out pin, master-in pin}
   localparam int unsigned SYNC_W   = 4;
   localparam logic [3:0]  SYNC_RST = 4'h8;
   localparam int unsigned SY_SS    = 3;
   localparam int unsigned SY_SCK   = 2;
   localparam int unsigned SY_MOSI  = 1;
   localparam int unsigned SY_MISO  = 0;
   // =======================================================
   // values after reset
   localparam logic [7:0] DATA_RST = 8'h00;
endpackage

// File: rtl/sfb_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/100ps
`default_nettype none
module sfb_sync
#(
   parameter int unsigned     W   = 4,
   parameter logic [W-1:0]    RST = '0
)
(
   input  wire logic          mclk,   // module clock
   input  wire logic          nrst,   // sync reset, active low
   input  wire logic          clkEn,  // freezes state when low
   input  wire logic [W-1:0]  din,    // asynchronous inputs
   output logic      [W-1:0]  dout    // synchronised copy
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sfb_sync_t;

   sfb_sync_t st;
   sfb_sync_t next_st;

   // =======================================================
   // first stage feeds only the second stage
   always_comb
   begin
      next_st = st;
      if (clkEn)
      begin
         next_st.s1 = din;
         next_st.s2 = st.s1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         st <= {RST, RST};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign dout = st.s2;
endmodule
`default_nettype wire
